// [src/devcfg_pkg.sv]
/*
 * Constants for the hub device configuration register.
 * Assumes a byte-wide register port shared by EEPROM load and SMBus host.
 */
package devcfg_pkg;
    localparam logic [7:0] DEVICE_CONFIGURATION_OFFSET = 8'h05;
    localparam int         STRING_WE_BIT               = 7;
    localparam int         SERIAL_WE_BIT               = 6;
    localparam int         LOWPOWER_DIS_BIT            = 5;
    localparam int         RSVD_ONE_BIT                = 4;
    localparam int         GANG_BIT                    = 3;
    localparam int         REPORT_DIS_BIT              = 2;
    localparam int         RSVD_RW_BIT                 = 1;
    localparam int         RSVD_ZERO_BIT               = 0;
    localparam int         NUM_PORTS                   = 4;
    localparam logic [7:0] WRITABLE_MASK               = 8'hEE;
    localparam logic [7:0] RESET_VALUE                 = 8'h10;
    localparam logic [3:0] ALL_PORTS_ON                = 4'hF;
    localparam logic [3:0] FIRST_PORT_ONLY             = 4'h1;
    localparam logic [3:0] NO_PORTS                    = 4'h0;

    typedef enum logic [1:0] {
        ST_RESET   = 2'b00,
        ST_CAPTURE = 2'b01,
        ST_RUN     = 2'b11
    } cfg_state_e;
endpackage

// [src/device_configuration_reg.sv]
/*
 * Hub device configuration register with strap capture, EEPROM load,
 * SMBus write, link low-power gating and port power switching outputs.
 * Assumes all inputs are synchronous to CLK_I; write strobes are one-cycle pulses.
 */
`timescale 1ns/100ps
module device_configuration_reg
    import devcfg_pkg::*;
(
    input  wire logic       CLK_I,
    input  wire logic       RESETN_I,
    input  wire logic       I2C_MODE_I,
    input  wire logic       EEPROM_LOAD_I,
    input  wire logic       SMBUS_WRITE_I,
    input  wire logic [7:0] REG_ADDR_I,
    input  wire logic [7:0] REG_WDATA_I,
    input  wire logic       GANG_STRAP_PIN_I,
    input  wire logic       POWER_REPORT_STRAP_PIN_I,
    input  wire logic       FORCED_LINK_PM_ACCEPT_MESSAGE_I,
    input  wire logic       UPSTREAM_DISCONNECT_I,
    input  wire logic [3:0] PORT_POWER_REQUEST_I,
    output logic [7:0]      REG_RDATA_O,
    output logic            STRING_REGS_WRITE_ENABLE_O,
    output logic            SERIAL_REGS_WRITE_ENABLE_O,
    output logic            LINK_LOWPOWER_ALLOWED_O,
    output logic            POWER_REPORT_ENABLE_O,
    output logic [3:0]      PORT_POWER_OUTPUTS_O
);

    cfg_state_e state_q, state_d;
    logic [7:0] cfg_q, cfg_d;
    logic       forced_q, forced_d;
    logic       report_en_q, report_en_d;
    logic [7:0] rdata_q, rdata_d;
    logic       lp_ok_q, lp_ok_d;
    logic [3:0] pwr_q, pwr_d;
    logic       hit;
    logic [7:0] view;

    // Read view forces the fixed reserved bits
    function automatic logic [7:0] read_view(input logic [7:0] r);
        logic [7:0] v;
        v = r;
        v[RSVD_ONE_BIT]  = 1'b1;
        v[RSVD_ZERO_BIT] = 1'b0;
        return v;
    endfunction

    // Configuration group: start-up sequence, strap capture, host writes
    always_comb begin
        hit     = (REG_ADDR_I == DEVICE_CONFIGURATION_OFFSET);
        state_d = state_q;
        cfg_d   = cfg_q;
        case (state_q)
            ST_RESET: begin
                state_d = ST_CAPTURE;
            end
            ST_CAPTURE: begin
                // Straps sampled on the second edge after release
                cfg_d[GANG_BIT]       = GANG_STRAP_PIN_I;
                cfg_d[REPORT_DIS_BIT] = POWER_REPORT_STRAP_PIN_I;
                state_d = ST_RUN;
            end
            ST_RUN: begin
                // Same path for both sources; mode picks which strobe counts
                if (hit && ((I2C_MODE_I && EEPROM_LOAD_I) ||
                            (!I2C_MODE_I && SMBUS_WRITE_I))) begin
                    // Read-only reserved bits never take write data
                    cfg_d = (cfg_q & ~WRITABLE_MASK) |
                            (REG_WDATA_I & WRITABLE_MASK);
                end
            end
            default: begin
                state_d = ST_RESET;
            end
        endcase
    end

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            state_q <= ST_RESET;
            cfg_q   <= RESET_VALUE;
        end else begin
            state_q <= state_d;
            cfg_q   <= cfg_d;
        end
    end

    // Link power group: sticky forced accept and the U1/U2 gate
    always_comb begin
        forced_d = forced_q;
        // Set wins over disconnect so a late message is never lost
        if (FORCED_LINK_PM_ACCEPT_MESSAGE_I) begin
            forced_d = 1'b1;
        end else if (UPSTREAM_DISCONNECT_I) begin
            forced_d = 1'b0;
        end
        lp_ok_d = !cfg_d[LOWPOWER_DIS_BIT] || forced_d;
    end

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            forced_q <= 1'b0;
            lp_ok_q  <= 1'b1;
        end else begin
            forced_q <= forced_d;
            lp_ok_q  <= lp_ok_d;
        end
    end

    // Output group: read view, report flag and port power enables
    always_comb begin
        view        = read_view(cfg_d);
        rdata_d     = view;
        report_en_d = !cfg_d[REPORT_DIS_BIT];
        if (cfg_d[REPORT_DIS_BIT]) begin
            // No status reporting, so ports are simply left powered
            pwr_d = ALL_PORTS_ON;
        end else if (cfg_d[GANG_BIT]) begin
            pwr_d = (|PORT_POWER_REQUEST_I) ? FIRST_PORT_ONLY : NO_PORTS;
        end else begin
            pwr_d = PORT_POWER_REQUEST_I;
        end
    end

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            rdata_q     <= RESET_VALUE;
            report_en_q <= 1'b1;
            pwr_q       <= NO_PORTS;
        end else begin
            rdata_q     <= rdata_d;
            report_en_q <= report_en_d;
            pwr_q       <= pwr_d;
        end
    end

    assign REG_RDATA_O                = rdata_q;
    assign STRING_REGS_WRITE_ENABLE_O = rdata_q[STRING_WE_BIT];
    assign SERIAL_REGS_WRITE_ENABLE_O = rdata_q[SERIAL_WE_BIT];
    assign LINK_LOWPOWER_ALLOWED_O    = lp_ok_q;
    assign POWER_REPORT_ENABLE_O      = report_en_q;
    assign PORT_POWER_OUTPUTS_O       = pwr_q;

    rsvd_one_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        REG_RDATA_O[RSVD_ONE_BIT] == 1'b1) else $error("bit 4 not one");
    rsvd_zero_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        REG_RDATA_O[RSVD_ZERO_BIT] == 1'b0) else $error("bit 0 not zero");
    gang_strap_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        state_q == ST_CAPTURE |=> REG_RDATA_O[GANG_BIT] == $past(GANG_STRAP_PIN_I))
        else $error("gang strap not captured");
    report_strap_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        state_q == ST_CAPTURE |=> REG_RDATA_O[REPORT_DIS_BIT] == $past(POWER_REPORT_STRAP_PIN_I))
        else $error("report strap not captured");
    smbus_write_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        state_q == ST_RUN && !I2C_MODE_I && SMBUS_WRITE_I && hit
        |=> REG_RDATA_O[LOWPOWER_DIS_BIT] == $past(REG_WDATA_I[LOWPOWER_DIS_BIT]))
        else $error("smbus write lost");
    eeprom_load_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        state_q == ST_RUN && I2C_MODE_I && EEPROM_LOAD_I && hit
        |=> REG_RDATA_O[GANG_BIT] == $past(REG_WDATA_I[GANG_BIT]))
        else $error("eeprom load lost");
    lowpower_block_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        REG_RDATA_O[LOWPOWER_DIS_BIT] && !forced_q |-> !LINK_LOWPOWER_ALLOWED_O)
        else $error("low power allowed while disabled");
    forced_sticky_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        forced_q && !UPSTREAM_DISCONNECT_I |=> LINK_LOWPOWER_ALLOWED_O)
        else $error("forced accept not honoured");
    ganged_power_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        state_q == ST_RUN && !cfg_d[REPORT_DIS_BIT] && cfg_d[GANG_BIT]
        |=> PORT_POWER_OUTPUTS_O[3:1] == 3'h0) else $error("ganged drives extra ports");
    string_reset_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        state_q == ST_CAPTURE |-> !STRING_REGS_WRITE_ENABLE_O && !SERIAL_REGS_WRITE_ENABLE_O)
        else $error("write enables not reset");
    report_flag_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        POWER_REPORT_ENABLE_O == !REG_RDATA_O[REPORT_DIS_BIT])
        else $error("report enable disagrees with bit 2");
    lowpower_allow_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        !REG_RDATA_O[LOWPOWER_DIS_BIT] |-> LINK_LOWPOWER_ALLOWED_O)
        else $error("low power blocked while enabled");
    forced_clear_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        !FORCED_LINK_PM_ACCEPT_MESSAGE_I && UPSTREAM_DISCONNECT_I |=> !forced_q)
        else $error("forced accept survives disconnect");
    string_write_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        state_q == ST_RUN && !I2C_MODE_I && SMBUS_WRITE_I && hit
        |=> STRING_REGS_WRITE_ENABLE_O == $past(REG_WDATA_I[STRING_WE_BIT]))
        else $error("string enable not written");
    serial_load_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        state_q == ST_RUN && I2C_MODE_I && EEPROM_LOAD_I && hit
        |=> SERIAL_REGS_WRITE_ENABLE_O == $past(REG_WDATA_I[SERIAL_WE_BIT]))
        else $error("serial enable not loaded");
    report_load_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        state_q == ST_RUN && I2C_MODE_I && EEPROM_LOAD_I && hit
        |=> REG_RDATA_O[REPORT_DIS_BIT] == $past(REG_WDATA_I[REPORT_DIS_BIT]))
        else $error("report bit not loaded");
    refused_write_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        state_q == ST_RUN && !(hit && (I2C_MODE_I ? EEPROM_LOAD_I : SMBUS_WRITE_I))
        |=> $stable(REG_RDATA_O)) else $error("register changed without a write");
    individual_power_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        state_q == ST_RUN && !cfg_d[REPORT_DIS_BIT] && !cfg_d[GANG_BIT]
        |=> PORT_POWER_OUTPUTS_O == $past(PORT_POWER_REQUEST_I))
        else $error("port power not switched per port");
    ganged_enable_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        state_q == ST_RUN && !cfg_d[REPORT_DIS_BIT] && cfg_d[GANG_BIT]
        |=> PORT_POWER_OUTPUTS_O[0] == ($past(PORT_POWER_REQUEST_I) != 4'h0))
        else $error("ganged enable wrong on first port");

endmodule // device_configuration_reg

// [tb/cfg_host_model.sv]
/* Host or EEPROM side model: issues single-byte configuration writes.
   Assumes the bench calls put() and clk_i is the design clock. */
`timescale 1ns/100ps
module cfg_host_model (
    input  wire logic       clk_i,
    output logic            eeprom_load_o,
    output logic            smbus_write_o,
    output logic [7:0]      addr_o,
    output logic [7:0]      wdata_o
);
    initial begin
        eeprom_load_o = 1'b0;
        smbus_write_o = 1'b0;
        addr_o = 8'h00;
        wdata_o = 8'h00;
    end
    // One-cycle strobe, then released lines show the inverse, not stale data
    task put(input logic eep, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        eeprom_load_o = eep;
        smbus_write_o = !eep;
        addr_o = a;
        wdata_o = d & 8'hFD;
        @(negedge clk_i);
        eeprom_load_o = 1'b0;
        smbus_write_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask
endmodule // cfg_host_model

// [tb/hub_device_config_register_bench.sv]
/* Self-checking bench for the device configuration register.
   Assumes the host model drives writes; all other inputs come from here. */
`timescale 1ns/100ps
module hub_device_config_register_bench;
    import devcfg_pkg::*;
    logic       clk, rst_n, mode, eep, smb, gang, rep, fa_in, disc, e;
    logic [7:0] addr, wdata, rdata, m, a;
    logic [3:0] req, pwr;
    logic       swe, nwe, lp, pre;
    int         n_errors, n_tests, fa;
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    cfg_host_model cfg_host_model_i (.clk_i(clk), .eeprom_load_o(eep), .smbus_write_o(smb),
        .addr_o(addr), .wdata_o(wdata));
    device_configuration_reg device_configuration_reg_i (.CLK_I(clk), .RESETN_I(rst_n),
        .I2C_MODE_I(mode), .EEPROM_LOAD_I(eep), .SMBUS_WRITE_I(smb), .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata), .GANG_STRAP_PIN_I(gang), .POWER_REPORT_STRAP_PIN_I(rep),
        .FORCED_LINK_PM_ACCEPT_MESSAGE_I(fa_in), .UPSTREAM_DISCONNECT_I(disc),
        .PORT_POWER_REQUEST_I(req), .REG_RDATA_O(rdata), .STRING_REGS_WRITE_ENABLE_O(swe),
        .SERIAL_REGS_WRITE_ENABLE_O(nwe), .LINK_LOWPOWER_ALLOWED_O(lp),
        .POWER_REPORT_ENABLE_O(pre), .PORT_POWER_OUTPUTS_O(pwr));
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task check_all;
        logic [3:0] p;
        p = m[2] ? 4'hF : (m[3] ? {3'h0, |req} : req);
        chk(rdata, m);
        chk({4'h0, swe, nwe, lp, pre},
            {4'h0, m[7], m[6], !m[5] || fa != 0, !m[2]});
        chk({4'h0, pwr}, {4'h0, p});
    endtask
    // Write through the host model; model takes it only on a hit in the right mode
    task wr(input logic we, input logic [7:0] wa, input logic [7:0] d);
        cfg_host_model_i.put(we, wa, d);
        if (wa == DEVICE_CONFIGURATION_OFFSET && we == mode)
            m = (m & ~WRITABLE_MASK) | (d & WRITABLE_MASK & 8'hFD);
        check_all;
    endtask
    task give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        void'($urandom(32'hFC25));
        {rst_n, mode, fa_in, disc, req, fa, n_errors, n_tests} = '0;
        gang = 1'($urandom);
        rep = 1'($urandom);
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        m = {4'h1, gang, rep, 2'h0};
        repeat (3) @(negedge clk);
        check_all;
        $display("test reset and straps done");
        for (int i = 0; i < 60; i++) begin
            @(negedge clk);
            mode = 1'($urandom);
            req = 4'($urandom);
            e = 1'($urandom);
            a = ($urandom % 4 == 0) ? 8'($urandom) : DEVICE_CONFIGURATION_OFFSET;
            wr(e, a, 8'($urandom));
        end
        $display("test random writes done");
        mode = 1'b0;
        wr(1'b0, DEVICE_CONFIGURATION_OFFSET, 8'h20);
        @(negedge clk);
        fa_in = 1'b1;
        @(negedge clk);
        fa_in = 1'b0;
        fa = 1;
        check_all;
        disc = 1'b1;
        fa_in = 1'b1;
        @(negedge clk);
        fa_in = 1'b0;
        check_all;
        @(negedge clk);
        disc = 1'b0;
        fa = 0;
        check_all;
        $display("test forced accept done");
        // Second release with flipped straps proves both capture levels
        @(negedge clk);
        rst_n = 1'b0;
        gang = ~gang;
        rep = ~rep;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        m = {4'h1, gang, rep, 2'h0};
        repeat (3) @(negedge clk);
        check_all;
        $display("test mid-run reset done");
        give_verdict;
    end
endmodule // hub_device_config_register_bench
